// >>> core/cies_core.sv
// Purpose: Fetches and executes the covered instruction subset, with an APB slave.
// Assumes: Program memory answers a fetch request with pmem_valid some cycles later.
// Notes: Every instruction walks the same six-step path, trading speed for simplicity.
`timescale 1ns/1ns
module cies_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] pmem_data,
  input wire logic pmem_valid,
  output logic [13:0] pmem_addr,
  output logic pmem_req,
  input wire logic [63:0] io_in,
  output logic [63:0] io_out,
  input wire logic [3:0] unlock_set,
  output logic [7:0] pll_reg,
  output logic [1:0] bank,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  cies_pkg::cies_state_t state;
  cies_pkg::cies_op_t op;
  cies_pkg::cies_instr_t f;
  cies_pkg::cies_frame_t stack [cies_pkg::CIES_STACK_DEPTH];
  cies_pkg::cies_frame_t top;
  logic [15:0] ir;
  logic [13:0] pc;
  logic [3:0] sp;
  logic [3:0] opa;
  logic [3:0] opb;
  logic [3:0] opc;
  logic [3:0] rd_data;
  logic [5:0] mem_raddr;
  logic mem_we;
  logic [5:0] mem_waddr;
  logic [3:0] mem_wdata;
  logic carry;
  logic skip_pending;
  logic next_skip;
  logic [3:0] status_reg [2];
  logic [3:0] unlock_ff;
  logic run;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] evt;
  logic exec;
  logic live;
  logic apb_wr;
  logic [3:0] st_sel;

  assign f = ir;
  assign exec = (state == cies_pkg::CIES_ST_EXEC);
  assign live = exec && !skip_pending;
  assign top = stack[3'(sp - 4'h1)];
  assign st_sel = status_reg[ir[4]];
  assign apb_wr = psel && penable && pready && pwrite;

  cies_dmem u_dmem (
    .core_clk(core_clk),
    .raddr(mem_raddr),
    .rdata(rd_data),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata)
  );

  // Sequencer: fetch, three operand reads, execute
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= cies_pkg::CIES_ST_IDLE;
    else
    begin
      unique case (state)
        cies_pkg::CIES_ST_IDLE: if (run) state <= cies_pkg::CIES_ST_FETCH;
        cies_pkg::CIES_ST_FETCH: if (pmem_valid) state <= cies_pkg::CIES_ST_ADDR;
        cies_pkg::CIES_ST_ADDR: state <= cies_pkg::CIES_ST_CAPA;
        cies_pkg::CIES_ST_CAPA: state <= cies_pkg::CIES_ST_CAPB;
        cies_pkg::CIES_ST_CAPB: state <= cies_pkg::CIES_ST_CAPC;
        cies_pkg::CIES_ST_CAPC: state <= cies_pkg::CIES_ST_EXEC;
        cies_pkg::CIES_ST_EXEC: state <= cies_pkg::CIES_ST_IDLE;
      endcase
    end
  end

  // Fetch request toward program memory
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pmem_req <= 1'b0;
      pmem_addr <= cies_pkg::CIES_PC_RST;
    end
    else
    begin
      pmem_req <= (state == cies_pkg::CIES_ST_IDLE) && run;
      if (state == cies_pkg::CIES_ST_IDLE)
        pmem_addr <= pc;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir <= 16'h0000;
      op <= cies_pkg::CIES_OP_NOP;
    end
    else if (state == cies_pkg::CIES_ST_FETCH && pmem_valid)
    begin
      ir <= pmem_data;
      op <= cies_pkg::cies_decode(pmem_data);
    end
  end

  // Read address per step; the third read is the indirect one
  always_comb
  begin
    mem_raddr = {f.row, f.col};
    unique case (state)
      cies_pkg::CIES_ST_CAPA:
        mem_raddr = (op == cies_pkg::CIES_OP_SRMOVE) ? {f.row, f.low} : {2'b00, f.low};
      cies_pkg::CIES_ST_CAPB: mem_raddr = {f.row, rd_data};
      default: mem_raddr = {f.row, f.col};
    endcase
  end

  // Operand capture
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opa <= 4'h0;
      opb <= 4'h0;
      opc <= 4'h0;
    end
    else
    begin
      if (state == cies_pkg::CIES_ST_CAPA) opa <= rd_data;
      if (state == cies_pkg::CIES_ST_CAPB) opb <= rd_data;
      if (state == cies_pkg::CIES_ST_CAPC) opc <= rd_data;
    end
  end

  // Memory write in the execute step; skipped words write nothing
  always_comb
  begin
    mem_we = 1'b0;
    mem_waddr = {f.row, f.col};
    mem_wdata = opa;
    if (live)
    begin
      unique case (op)
        cies_pkg::CIES_OP_XOR_REG:
        begin
          mem_we = 1'b1;
          mem_waddr = {2'b00, f.low};
          mem_wdata = opb ^ opa;
        end
        cies_pkg::CIES_OP_XOR_IMM:
        begin
          mem_we = 1'b1;
          mem_wdata = opa ^ f.low;
        end
        cies_pkg::CIES_OP_SHIFT:
        begin
          mem_we = 1'b1;
          mem_waddr = {2'b00, f.low};
          mem_wdata = {carry, opb[3:1]};
        end
        cies_pkg::CIES_OP_ISTORE:
        begin
          mem_we = 1'b1;
          mem_waddr = {f.row, opb};
        end
        cies_pkg::CIES_OP_ILOAD:
        begin
          mem_we = 1'b1;
          mem_wdata = opc;
        end
        cies_pkg::CIES_OP_SRMOVE:
        begin
          mem_we = 1'b1;
          mem_wdata = opb;
        end
        cies_pkg::CIES_OP_REG_IN:
        begin
          mem_we = 1'b1;
          mem_wdata = io_in[{f.low, 2'b00} +: 4];
        end
        default: mem_we = 1'b0;
      endcase
    end
  end

  // Skip decisions of the test instructions
  always_comb
  begin
    next_skip = 1'b0;
    unique case (op)
      cies_pkg::CIES_OP_MTEST_T: next_skip = ((opa & f.low) == f.low);
      cies_pkg::CIES_OP_MTEST_F: next_skip = ((opa & f.low) == 4'h0);
      cies_pkg::CIES_OP_STEST_T: next_skip = ((st_sel & f.low) == f.low);
      cies_pkg::CIES_OP_STEST_F: next_skip = ((st_sel & f.low) == 4'h0);
      cies_pkg::CIES_OP_ULTEST: next_skip = ((unlock_ff & f.low) == 4'h0);
      default: next_skip = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      skip_pending <= 1'b0;
    else if (exec)
      skip_pending <= live && next_skip;
  end

  // Program counter, return stack and bank
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc <= cies_pkg::CIES_PC_RST;
      sp <= 4'h0;
      bank <= 2'b00;
      for (int i = 0; i < cies_pkg::CIES_STACK_DEPTH; i++)
        stack[i] <= '0;
    end
    else if (exec)
    begin
      pc <= pc + 14'h0001;
      if (live)
      begin
        unique case (op)
          cies_pkg::CIES_OP_CALL:
          begin
            pc <= {2'b00, ir[11:0]};
            if (sp != cies_pkg::CIES_SP_FULL)
            begin
              stack[sp[2:0]] <= '{bank: bank, pc: pc + 14'h0001};
              sp <= sp + 4'h1;
            end
          end
          cies_pkg::CIES_OP_RET, cies_pkg::CIES_OP_RET_SKIP, cies_pkg::CIES_OP_RET_BANK,
          cies_pkg::CIES_OP_RET_BANK_SKIP:
          begin
            if (sp != 4'h0)
            begin
              sp <= sp - 4'h1;
              pc <= top.pc;
              if (op == cies_pkg::CIES_OP_RET_SKIP || op == cies_pkg::CIES_OP_RET_BANK_SKIP)
                pc <= top.pc + 14'h0001;
              if (op == cies_pkg::CIES_OP_RET_BANK || op == cies_pkg::CIES_OP_RET_BANK_SKIP)
                bank <= top.bank;
            end
          end
          default: pc <= pc + 14'h0001;
        endcase
      end
    end
  end

  // carry takes the bit shifted out
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      carry <= 1'b0;
    else if (live && op == cies_pkg::CIES_OP_SHIFT)
      carry <= opb[0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_reg[0] <= 4'h0;
      status_reg[1] <= 4'h0;
    end
    else if (live && op == cies_pkg::CIES_OP_SSET)
      status_reg[ir[4]] <= st_sel | f.low;
    else if (live && op == cies_pkg::CIES_OP_SCLR)
      status_reg[ir[4]] <= st_sel & ~f.low;
  end

  // Unlock flags: a new set beats the clear done by the test
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      unlock_ff <= 4'h0;
    else if (live && op == cies_pkg::CIES_OP_ULTEST)
      unlock_ff <= (unlock_ff & ~f.low) | unlock_set;
    else
      unlock_ff <= unlock_ff | unlock_set;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pll_reg <= 8'h00;
    else if (live && op == cies_pkg::CIES_OP_PLL)
      pll_reg <= {opa, opb};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      io_out <= 64'h0000000000000000;
    else if (live && op == cies_pkg::CIES_OP_REG_OUT)
      io_out[{f.low, 2'b00} +: 4] <= opa;
  end

  // Events that feed the interrupt status
  always_comb
  begin
    evt = 4'h0;
    evt[cies_pkg::CIES_EVT_SKIP] = live && next_skip;
    evt[cies_pkg::CIES_EVT_PLL] = live && op == cies_pkg::CIES_OP_PLL;
    evt[cies_pkg::CIES_EVT_OVF] = live && op == cies_pkg::CIES_OP_CALL &&
      sp == cies_pkg::CIES_SP_FULL;
    evt[cies_pkg::CIES_EVT_UNF] = live && sp == 4'h0 &&
      (op == cies_pkg::CIES_OP_RET || op == cies_pkg::CIES_OP_RET_SKIP ||
       op == cies_pkg::CIES_OP_RET_BANK || op == cies_pkg::CIES_OP_RET_BANK_SKIP);
  end

  // Sticky status, write one to clear; set wins over clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat <= 4'h0;
    else if (apb_wr && paddr == cies_pkg::CIES_OFS_IRQ_STAT)
      irq_stat <= (irq_stat & ~pwdata[3:0]) | evt;
    else
      irq_stat <= irq_stat | evt;
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // Writable control and mask registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run <= cies_pkg::CIES_RUN_RST;
      irq_mask <= cies_pkg::CIES_MASK_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == cies_pkg::CIES_OFS_CTRL) run <= pwdata[0];
      if (paddr == cies_pkg::CIES_OFS_IRQ_MASK) irq_mask <= pwdata[3:0];
    end
  end

  // APB answer: one wait state, read data and error registered
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && penable && !pready)
      begin
        unique case (paddr)
          cies_pkg::CIES_OFS_CTRL: prdata <= {31'h00000000, run};
          cies_pkg::CIES_OFS_IRQ_STAT: prdata <= {28'h0000000, irq_stat};
          cies_pkg::CIES_OFS_IRQ_MASK: prdata <= {28'h0000000, irq_mask};
          cies_pkg::CIES_OFS_CORE_VIEW:
            prdata <= {10'h000, sp, skip_pending, carry, bank, pc};
          cies_pkg::CIES_OFS_PLL_VIEW: prdata <= {24'h000000, pll_reg};
          cies_pkg::CIES_OFS_FLAG_VIEW:
            prdata <= {20'h00000, unlock_ff, status_reg[1], status_reg[0]};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Six-step instruction path
  sequence s_operand_walk;
    state == cies_pkg::CIES_ST_ADDR ##1 state == cies_pkg::CIES_ST_CAPA ##1
    state == cies_pkg::CIES_ST_CAPB ##1 state == cies_pkg::CIES_ST_CAPC ##1 exec;
  endsequence

  property p_walk;
    @(posedge core_clk) disable iff (!rst_n)
    (state == cies_pkg::CIES_ST_FETCH && pmem_valid) |=> s_operand_walk;
  endproperty
  a_walk: assert property (p_walk) else $error("instruction path broken");

  property p_xor_imm;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_XOR_IMM) |->
      mem_we && mem_waddr == {f.row, f.col} && mem_wdata == (opa ^ f.low);
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("immediate xor wrong");

  property p_shift_carry;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_SHIFT) |=> carry == $past(opb[0]);
  endproperty
  a_shift_carry: assert property (p_shift_carry) else $error("carry not shifted");

  property p_mtest_true;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_MTEST_T && (opa & f.low) == f.low) |=> skip_pending;
  endproperty
  a_mtest_true: assert property (p_mtest_true) else $error("test true no skip");

  property p_mtest_false;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_MTEST_F) |=> skip_pending == ($past(opa & f.low) == 4'h0);
  endproperty
  a_mtest_false: assert property (p_mtest_false) else $error("test false skip wrong");

  property p_call;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_CALL && sp != cies_pkg::CIES_SP_FULL) |=>
      pc == {2'b00, $past(ir[11:0])} && top.pc == $past(pc) + 14'h0001;
  endproperty
  a_call: assert property (p_call) else $error("call wrong");

  property p_ret_skip;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_RET_SKIP && sp != 4'h0) |=>
      pc == $past(top.pc) + 14'h0001;
  endproperty
  a_ret_skip: assert property (p_ret_skip) else $error("return skip wrong");

  property p_ret_bank;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_RET_BANK && sp != 4'h0) |=>
      pc == $past(top.pc) && bank == $past(top.bank);
  endproperty
  a_ret_bank: assert property (p_ret_bank) else $error("bank return wrong");

  property p_status_set;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_SSET) |=> (st_sel & f.low) == f.low;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status set failed");

  property p_ultest;
    @(posedge core_clk) disable iff (!rst_n)
    (live && op == cies_pkg::CIES_OP_ULTEST && (unlock_ff & f.low) != 4'h0) |=> !skip_pending;
  endproperty
  a_ultest: assert property (p_ultest) else $error("unlock test skipped");

  property p_skip_quiet;
    @(posedge core_clk) disable iff (!rst_n)
    (exec && skip_pending) |-> !mem_we ##1 (!skip_pending && $stable(pll_reg) && $stable(sp));
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("skipped word acted");

endmodule : cies_core

// >>> core/cies_pkg.sv
// Purpose: Shared constants, types and decode for the instruction execute subset.
// Assumes: One 250 MHz core clock; instructions arrive one word per fetch.
// Notes: Opcode values below are the execute unit's own map of the instruction word.
// Notes on behaviour
// - Register becomes register XOR memory nibble
// - Memory nibble XOR immediate low field
// - Shift register right through carry flag
// - Indirect moves use column from register
// - Same row copy, source to destination
// - Skip when all masked bits one
// - Skip when all masked bits zero
// - Call pushes pc plus one, loads address
// - Return with skip: popped value plus one
// - Bank return restores pc and bank
// - Bank return skip: bank, popped plus one
// - Status set; test true skips when ones
// - Status clear; test false skips when zeros
// - Skip when selected unlock flags clear
// - Load divider nibbles into pll register
// - Copy internal register into memory nibble
// - Write memory nibble to internal register
package cies_pkg;

  // Register map, byte addresses
  localparam logic [7:0] CIES_OFS_CTRL = 8'h00;
  localparam logic [7:0] CIES_OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] CIES_OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] CIES_OFS_CORE_VIEW = 8'h0C;
  localparam logic [7:0] CIES_OFS_PLL_VIEW = 8'h10;
  localparam logic [7:0] CIES_OFS_FLAG_VIEW = 8'h14;

  // Reset values
  localparam logic CIES_RUN_RST = 1'b1;
  localparam logic [3:0] CIES_MASK_RST = 4'h0;
  localparam logic [13:0] CIES_PC_RST = 14'h0000;

  // Event bit positions in the interrupt status register
  localparam int CIES_EVT_SKIP = 0;
  localparam int CIES_EVT_PLL = 1;
  localparam int CIES_EVT_OVF = 2;
  localparam int CIES_EVT_UNF = 3;

  // Group codes: six bits, call four bits, page codes eight bits
  localparam logic [5:0] CIES_G_XOR_REG = 6'h0C;
  localparam logic [5:0] CIES_G_XOR_IMM = 6'h0D;
  localparam logic [5:0] CIES_G_REG_IN = 6'h0E;
  localparam logic [5:0] CIES_G_REG_OUT = 6'h0F;
  localparam logic [5:0] CIES_G_ISTORE = 6'h36;
  localparam logic [5:0] CIES_G_ILOAD = 6'h37;
  localparam logic [5:0] CIES_G_SRMOVE = 6'h38;
  localparam logic [5:0] CIES_G_MTEST_T = 6'h3C;
  localparam logic [5:0] CIES_G_MTEST_F = 6'h3D;
  localparam logic [5:0] CIES_G_PLL = 6'h3E;
  localparam logic [3:0] CIES_G_CALL = 4'hC;
  localparam logic [7:0] CIES_HI_LOW = 8'h00;
  localparam logic [7:0] CIES_HI_HIGH = 8'hFF;
  // Sub codes in bits 7:4 (low page) and bits 7:4 or 7:5 (high page)
  localparam logic [3:0] CIES_S_RET = 4'h8;
  localparam logic [3:0] CIES_S_RET_SKIP = 4'hA;
  localparam logic [3:0] CIES_S_ULTEST = 4'hD;
  localparam logic [3:0] CIES_S_SHIFT = 4'hE;
  localparam logic [3:0] CIES_S_RET_BANK = 4'hC;
  localparam logic [3:0] CIES_S_RET_BANK_SKIP = 4'hD;
  localparam logic [2:0] CIES_S_SSET = 3'h0;
  localparam logic [2:0] CIES_S_SCLR = 3'h1;
  localparam logic [2:0] CIES_S_STEST_T = 3'h2;
  localparam logic [2:0] CIES_S_STEST_F = 3'h4;

  // Return stack
  localparam int CIES_STACK_DEPTH = 8;
  localparam logic [3:0] CIES_SP_FULL = 4'h8;

  typedef struct packed {
    logic [5:0] group;
    logic [1:0] row;
    logic [3:0] col;
    logic [3:0] low;
  } cies_instr_t;

  typedef struct packed {
    logic [1:0] bank;
    logic [13:0] pc;
  } cies_frame_t;

  typedef enum logic [2:0] {
    CIES_ST_IDLE, CIES_ST_FETCH, CIES_ST_ADDR, CIES_ST_CAPA, CIES_ST_CAPB, CIES_ST_CAPC,
    CIES_ST_EXEC
  } cies_state_t;

  typedef enum logic [4:0] {
    CIES_OP_NOP, CIES_OP_XOR_REG, CIES_OP_XOR_IMM, CIES_OP_SHIFT, CIES_OP_ISTORE,
    CIES_OP_ILOAD, CIES_OP_SRMOVE, CIES_OP_MTEST_T, CIES_OP_MTEST_F, CIES_OP_CALL,
    CIES_OP_RET, CIES_OP_RET_SKIP, CIES_OP_RET_BANK, CIES_OP_RET_BANK_SKIP, CIES_OP_SSET,
    CIES_OP_SCLR, CIES_OP_STEST_T, CIES_OP_STEST_F, CIES_OP_ULTEST, CIES_OP_PLL,
    CIES_OP_REG_IN, CIES_OP_REG_OUT
  } cies_op_t;

  // Group from the top bits first, then sub fields
  function automatic cies_op_t cies_decode(input logic [15:0] w);
    cies_op_t op;
    op = CIES_OP_NOP;
    if (w[15:12] == CIES_G_CALL)
      op = CIES_OP_CALL;
    else if (w[15:8] == CIES_HI_LOW)
    begin
      if (w[7:4] == CIES_S_RET) op = CIES_OP_RET;
      else if (w[7:4] == CIES_S_RET_SKIP) op = CIES_OP_RET_SKIP;
      else if (w[7:4] == CIES_S_ULTEST) op = CIES_OP_ULTEST;
      else if (w[7:4] == CIES_S_SHIFT) op = CIES_OP_SHIFT;
    end
    else if (w[15:8] == CIES_HI_HIGH)
    begin
      if (w[7:4] == CIES_S_RET_BANK) op = CIES_OP_RET_BANK;
      else if (w[7:4] == CIES_S_RET_BANK_SKIP) op = CIES_OP_RET_BANK_SKIP;
      else if (w[7:5] == CIES_S_SSET) op = CIES_OP_SSET;
      else if (w[7:5] == CIES_S_SCLR) op = CIES_OP_SCLR;
      else if (w[7:5] == CIES_S_STEST_T) op = CIES_OP_STEST_T;
      else if (w[7:5] == CIES_S_STEST_F) op = CIES_OP_STEST_F;
    end
    else
    begin
      unique case (w[15:10])
        CIES_G_XOR_REG: op = CIES_OP_XOR_REG;
        CIES_G_XOR_IMM: op = CIES_OP_XOR_IMM;
        CIES_G_REG_IN: op = CIES_OP_REG_IN;
        CIES_G_REG_OUT: op = CIES_OP_REG_OUT;
        CIES_G_ISTORE: op = CIES_OP_ISTORE;
        CIES_G_ILOAD: op = CIES_OP_ILOAD;
        CIES_G_SRMOVE: op = CIES_OP_SRMOVE;
        CIES_G_MTEST_T: op = CIES_OP_MTEST_T;
        CIES_G_MTEST_F: op = CIES_OP_MTEST_F;
        CIES_G_PLL: op = CIES_OP_PLL;
        default: op = CIES_OP_NOP;
      endcase
    end
    return op;
  endfunction : cies_decode

endpackage : cies_pkg

// >>> core/cies_dmem.sv
// Purpose: Data memory of 64 nibbles, four rows of sixteen columns.
// Assumes: One write and one read per cycle on core_clk.
// Notes: Read data is registered, so it follows the address by one cycle.
`timescale 1ns/1ns
module cies_dmem (
  input wire logic core_clk,
  input wire logic [5:0] raddr,
  output logic [3:0] rdata,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [3:0] wdata
);

  logic [3:0] mem [64];

  // Content is not reset; software initialises what it uses
  always_ff @(posedge core_clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Registered read port
  always_ff @(posedge core_clk)
  begin
    rdata <= mem[raddr];
  end

endmodule : cies_dmem

// >>> test/cies_pmem_model.sv
// Purpose: Program memory model that answers fetches with sixteen-bit words.
// Assumes: One request pulse per fetch, address held until the next one.
// Notes: Odd addresses answer three cycles late; data churns while not valid.
`timescale 1ns/1ns
module cies_pmem_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pmem_req,
  input wire logic [13:0] pmem_addr,
  output logic [15:0] pmem_data,
  output logic pmem_valid
);
  logic [15:0] prog [0:31];
  logic [2:0] wait_cnt;
  logic busy;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      wait_cnt <= 3'h0;
      pmem_valid <= 1'b0;
      pmem_data <= 16'h0000;
    end
    else
    begin
      busy <= pmem_req | (busy & (wait_cnt != 3'h0));
      wait_cnt <= pmem_req ? (pmem_addr[0] ? 3'h3 : 3'h0) : wait_cnt - 3'h1;
      pmem_valid <= !pmem_req && busy && wait_cnt == 3'h0;
      // Inverted word when idle, so a stale bus never looks valid
      pmem_data <= (!pmem_req && busy && wait_cnt == 3'h0) ? prog[pmem_addr[4:0]] : ~pmem_data;
    end
  end
endmodule : cies_pmem_model

// >>> test/tb_top.sv
// Purpose: Self-checking bench running a small program through the core.
// Assumes: Operands drawn once from the xorshift seed before reset release.
// Notes: Loop at word 15 fills the stack; APB then inspects status and interrupt.
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [63:0] io_in = 64'h0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pmem_valid, pmem_req, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00, pll_reg;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hCE07;
  logic [15:0] pmem_data;
  logic [13:0] pmem_addr;
  logic [63:0] io_out;
  logic [1:0] bank;
  logic [3:0] x, y, unlock_set = 4'h0;
  logic err;
  int fail_count = 0, check_count = 0, i;
  `define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
  cies_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .pmem_data(pmem_data),
    .pmem_valid(pmem_valid), .pmem_addr(pmem_addr), .pmem_req(pmem_req), .io_in(io_in),
    .io_out(io_out), .unlock_set(unlock_set), .pll_reg(pll_reg), .bank(bank), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  cies_pmem_model i_pmem (.core_clk(core_clk), .rst_n(rst_n), .pmem_req(pmem_req),
    .pmem_addr(pmem_addr), .pmem_data(pmem_data), .pmem_valid(pmem_valid));
  // Free-running 250 MHz clock
  always #2 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic complete_run;
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Waits for pready under a bound; request held until that edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge core_clk); i++; end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (i >= 50) begin fail_count++; complete_run(); end
  endtask : apb
  initial
  begin
    seed = xs(seed);
    io_in <= {xs(seed), seed};
    x = seed[11:8] ^ seed[19:16];
    y = seed[15:12] ^ x;
    // Program built around the drawn operands; words 16 to 21 are the subroutine
    i_pmem.prog = '{16'h3812, 16'h3823, {12'h341, seed[19:16]}, 16'h3012, 16'h3C25, 16'h00E2,
      16'h3C26, {12'hF01, x}, 16'h3C17, 16'hC010, 16'h3C18, 16'hFF05, 16'hFF85, 16'h3C39,
      16'hF812, 16'hC00F, 16'h00D1, 16'hFF1F, 16'h00D1, 16'hFF3F, 16'hE031, 16'h00A0, 16'h0,
      16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    // One unlock pulse, so the first flag test must not skip and the second must
    unlock_set <= 4'h1;
    @(posedge core_clk);
    unlock_set <= 4'h0;
    i = 0;
    while (pmem_addr !== 14'h00F && i < 3000) begin @(posedge core_clk); i++; end
    if (i >= 3000) begin fail_count++; complete_run(); end
    repeat (200) @(posedge core_clk);
    `CHK("slot5", y, io_out[23:20])
    `CHK("slot6", {1'b0, y[3:1]}, io_out[27:24])
    `CHK("slot7", 4'h0, io_out[31:28])
    `CHK("slot8", 4'h0, io_out[35:32])
    `CHK("slot9", x, io_out[39:36])
    `CHK("pll", {x, 1'b0, y[3:1]}, pll_reg)
    `CHK("bank", 2'h0, bank)
    apb(1'b1, 8'h00, 32'h0);
    repeat (30) @(posedge core_clk);
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("pc", 14'h00F, rd[13:0])
    `CHK("depth", 4'h8, rd[21:18])
    // Unlock flag tested twice; status one set once, its clear skipped
    apb(1'b0, 8'h14, 32'h0);
    `CHK("flags", 12'h0F5, rd[11:0])
    apb(1'b0, 8'h04, 32'h0);
    `CHK("stat", 4'h7, rd[3:0])
    `CHK("irq off", 1'b0, irq)
    apb(1'b1, 8'h08, 32'h4);
    @(posedge core_clk);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, 8'h04, 32'h4);
    @(posedge core_clk);
    `CHK("irq clr", 1'b0, irq)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err)
    complete_run();
  end
endmodule : tb_top
